// ==== ewwrf_defines.svh ====
// register offsets, field positions, reset values and timing counts of the guard timer
`ifndef EWWRF_DEFINES_SVH
`define EWWRF_DEFINES_SVH

`define EWWRF_ADDR_RESET_CAUSE 8'h55
`define EWWRF_ADDR_CONTROL 8'h60

`define EWWRF_CTL_IRQ_FLAG 7
`define EWWRF_CTL_IRQ_EN 6
`define EWWRF_CTL_PRE_HI 5
`define EWWRF_CTL_CHG_EN 4
`define EWWRF_CTL_RST_EN 3
`define EWWRF_CTL_PRE_LO_MSB 2

`define EWWRF_CAUSE_GUARD 3
`define EWWRF_CAUSE_BROWNOUT 2
`define EWWRF_CAUSE_PIN 1
`define EWWRF_CAUSE_POWERUP 0
`define EWWRF_CAUSE_POR_VALUE 4'h1

`define EWWRF_OSC_FREQ_KHZ 128
`define EWWRF_SYS_FREQ_KHZ 10000
`define EWWRF_CHANGE_WINDOW 3'h4
`define EWWRF_BASE_TIMEOUT 21'h000800
`define EWWRF_PRESCALE_MAX 4'h9

`endif

// ==== ewwrf_pkg.sv ====
// mode type used by the guard timer module
package ewwrf_pkg;

  typedef enum logic [3:0] {
    EWWRF_MODE_STOPPED  = 4'b0001,
    EWWRF_MODE_IRQ      = 4'b0010,
    EWWRF_MODE_RESET    = 4'b0100,
    EWWRF_MODE_COMBINED = 4'b1000
  } ewwrf_mode_t;

endpackage : ewwrf_pkg

// ==== ewwrf_sync.sv ====
// two-flop level synchroniser
`timescale 1ns/10ps

module ewwrf_sync (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_async,
  output logic o_sync
);

  logic meta_reg;

  // first flop feeds only the second one
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      meta_reg <= 1'b0;
      o_sync <= 1'b0;
    end else begin
      meta_reg <= i_async;
      o_sync <= meta_reg;
    end
  end

endmodule : ewwrf_sync

// ==== ewwrf_guard_timer.sv ====
// guard timer with reset-cause flags, timed change sequence and register port
// Functional notes
// (RULE_01) counter advances on edges of the separate 128 kHz oscillator
// (RULE_02) restart clears counter; otherwise interrupt or reset at time-out
// (RULE_03) interrupt mode raises a request at expiry that can wake from sleep
// (RULE_04) reset mode asserts system reset at expiry
// (RULE_05) combined mode: first expiry interrupts, later expiry resets
// (RULE_06) always-on fuse forces reset enable to 1 and interrupt enable to 0
// (RULE_07) software opens a change with change enable and reset enable both one
// (RULE_08) reset-enable clear or prescaler change accepted only in four-cycle window
// (RULE_09) time-out spans about 16 ms up to about 8 s
// (RULE_10) software restarts before shortening the prescaler
// (RULE_11) guard reset flag bit 3: set by guard reset, cleared by power-on or zero
// (RULE_12) brown-out flag bit 2: set by brown-out, cleared by power-on or zero
// (RULE_13) pin reset flag bit 1: set by pin reset, cleared by power-on or zero
// (RULE_14) power-up flag bit 0: set by power-on, cleared only by writing zero
// (RULE_15) reset-cause bits 7..4 read as zero
// (RULE_16) control layout: flag, irq en, pre3, change en, reset en, pre2..0
// (RULE_17) interrupt flag sets on time-out, cleared by vector or by writing one
// (RULE_18) interrupt taken only with global enable and irq enable both set
// (RULE_19) accidental enable resets and stays enabled after the reset
// (RULE_20) start-up code clears guard reset flag and reset enable
// (RULE_21) software reads then clears reset-cause early after start-up
// (RULE_22) while guard reset flag is set reset enable reads one
// (RULE_23) four prescaler bits select 2048 to 1048576 cycles, codes above nine reserved
// (RULE_24) change enable self-clears four system cycles after being written
// (RULE_25) vector in combined mode clears irq enable and flag
// (RULE_26) oscillator brought safely into the system clock domain
//
// The plain strobed port was left to the implementer.
`timescale 1ns/10ps
`include "ewwrf_defines.svh"

module ewwrf_guard_timer #(
  parameter int CNT_W = 20,
  parameter int PRE_W = 4
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_guard_osc,
  input wire logic i_guard_restart,
  input wire logic i_guard_always_on_fuse,
  input wire logic i_global_irq_enable,
  input wire logic i_irq_vector_taken,
  input wire logic i_brownout_reset,
  input wire logic i_pin_reset,
  output logic [7:0] o_rdata,
  output logic o_guard_irq,
  output logic o_guard_wake,
  output logic o_guard_system_reset,
  output logic o_guard_running
);

  // state

  logic irq_flag_reg;
  logic irq_flag_next;
  logic irq_en_reg;
  logic irq_en_next;
  logic rst_en_reg;
  logic rst_en_next;
  logic [PRE_W-1:0] pre_reg;
  logic [PRE_W-1:0] pre_next;
  logic [2:0] win_reg;
  logic [2:0] win_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic [3:0] cause_reg;
  logic [3:0] cause_next;
  logic osc_prev_reg;
  logic [7:0] rdata_next;
  logic irq_out_next;
  logic wake_next;
  logic sys_reset_next;

  // oscillator edge detect

  logic osc_sync_w;
  logic tick_w;

  ewwrf_sync u_osc_sync (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_async(i_guard_osc),
    .o_sync(osc_sync_w)
  ); // [RULE_26]

  // edge detector looks only at the second flop
  assign tick_w = osc_sync_w & ~osc_prev_reg; // [RULE_01] [RULE_26]

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      osc_prev_reg <= 1'b0;
    end else begin
      osc_prev_reg <= osc_sync_w;
    end
  end

  // register port decode

  logic hit_ctl_w;
  logic hit_cause_w;
  logic wr_ctl_w;
  logic wr_cause_w;
  logic open_w;
  logic in_win_w;
  logic commit_w;
  logic w1c_flag_w;

  assign hit_ctl_w = (i_addr == `EWWRF_ADDR_CONTROL);
  assign hit_cause_w = (i_addr == `EWWRF_ADDR_RESET_CAUSE);
  assign wr_ctl_w = i_wr & hit_ctl_w;
  assign wr_cause_w = i_wr & hit_cause_w;
  assign in_win_w = (win_reg != 3'h0);
  // opening write needs both bits in one go
  assign open_w = wr_ctl_w & i_wdata[`EWWRF_CTL_CHG_EN] & i_wdata[`EWWRF_CTL_RST_EN]; // [RULE_07]
  // second write inside the window, change enable cleared
  assign commit_w = wr_ctl_w & in_win_w & ~i_wdata[`EWWRF_CTL_CHG_EN]; // [RULE_08]
  assign w1c_flag_w = wr_ctl_w & i_wdata[`EWWRF_CTL_IRQ_FLAG]; // [RULE_17]

  // chip-wide resets other than power-on restore control but keep the cause flags
  logic chip_reset_w;
  assign chip_reset_w = i_brownout_reset | i_pin_reset | o_guard_system_reset;

  // effective mode

  logic eff_rst_en_w;
  logic eff_irq_en_w;
  logic running_w;
  ewwrf_pkg::ewwrf_mode_t mode_w;

  // flag and fuse both pin reset enable high, so a stray enable survives its own reset
  assign eff_rst_en_w = rst_en_reg | cause_reg[`EWWRF_CAUSE_GUARD] | i_guard_always_on_fuse; // [RULE_06] [RULE_19] [RULE_22]
  assign eff_irq_en_w = irq_en_reg & ~i_guard_always_on_fuse; // [RULE_06]
  assign running_w = eff_rst_en_w | eff_irq_en_w;

  assign mode_w = ({eff_rst_en_w, eff_irq_en_w} == 2'b11) ? ewwrf_pkg::EWWRF_MODE_COMBINED :
                  ({eff_rst_en_w, eff_irq_en_w} == 2'b10) ? ewwrf_pkg::EWWRF_MODE_RESET :
                  ({eff_rst_en_w, eff_irq_en_w} == 2'b01) ? ewwrf_pkg::EWWRF_MODE_IRQ :
                  ewwrf_pkg::EWWRF_MODE_STOPPED;

  // time-out selection

  logic [PRE_W-1:0] pre_eff_w;
  logic [20:0] limit_w;
  logic [CNT_W-1:0] limit_m1_w;
  logic expire_w;

  // reserved codes behave as the longest setting rather than wrapping short
  assign pre_eff_w = (pre_reg > `EWWRF_PRESCALE_MAX) ? `EWWRF_PRESCALE_MAX : pre_reg; // [RULE_23]
  assign limit_w = `EWWRF_BASE_TIMEOUT << pre_eff_w; // [RULE_09] [RULE_23]
  assign limit_m1_w = CNT_W'(limit_w - 21'h000001);
  assign expire_w = running_w & tick_w & (cnt_reg == limit_m1_w);

  // counter

  always_comb begin
    if (chip_reset_w || i_guard_restart || !running_w || expire_w) begin
      cnt_next = '0; // [RULE_02]
    end else if (tick_w) begin
      cnt_next = cnt_reg + CNT_W'(1); // [RULE_01]
    end else begin
      cnt_next = cnt_reg;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // timed change window

  always_comb begin
    if (chip_reset_w) begin
      win_next = 3'h0;
    end else if (open_w) begin
      win_next = `EWWRF_CHANGE_WINDOW; // [RULE_24]
    end else if (commit_w) begin
      win_next = 3'h0;
    end else if (in_win_w) begin
      win_next = win_reg - 3'h1; // [RULE_24]
    end else begin
      win_next = 3'h0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      win_reg <= 3'h0;
    end else begin
      win_reg <= win_next;
    end
  end

  // reset enable and prescaler

  always_comb begin
    rst_en_next = rst_en_reg;
    pre_next = pre_reg;
    if (chip_reset_w) begin
      rst_en_next = 1'b0;
      pre_next = '0;
    end else if (commit_w) begin
      rst_en_next = i_wdata[`EWWRF_CTL_RST_EN]; // [RULE_08]
      pre_next = {i_wdata[`EWWRF_CTL_PRE_HI], i_wdata[`EWWRF_CTL_PRE_LO_MSB:0]}; // [RULE_08] [RULE_16]
    end else if (wr_ctl_w) begin
      // outside the window a write may only set reset enable
      rst_en_next = rst_en_reg | i_wdata[`EWWRF_CTL_RST_EN]; // [RULE_08]
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      rst_en_reg <= 1'b0;
      pre_reg <= '0;
    end else begin
      rst_en_reg <= rst_en_next;
      pre_reg <= pre_next;
    end
  end

  // interrupt enable and flag

  logic vec_clear_en_w;
  assign vec_clear_en_w = i_irq_vector_taken & (mode_w == ewwrf_pkg::EWWRF_MODE_COMBINED);

  always_comb begin
    if (chip_reset_w) begin
      irq_en_next = 1'b0;
    end else if (vec_clear_en_w) begin
      irq_en_next = 1'b0; // [RULE_25]
    end else if (wr_ctl_w) begin
      irq_en_next = i_wdata[`EWWRF_CTL_IRQ_EN];
    end else begin
      irq_en_next = irq_en_reg;
    end
  end

  // a time-out in the clearing cycle still lands
  always_comb begin
    if (chip_reset_w) begin
      irq_flag_next = 1'b0;
    end else if (expire_w && eff_irq_en_w) begin
      irq_flag_next = 1'b1; // [RULE_03] [RULE_05] [RULE_17]
    end else if (i_irq_vector_taken || w1c_flag_w) begin
      irq_flag_next = 1'b0; // [RULE_17] [RULE_25]
    end else begin
      irq_flag_next = irq_flag_reg;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      irq_en_reg <= 1'b0;
      irq_flag_reg <= 1'b0;
    end else begin
      irq_en_reg <= irq_en_next;
      irq_flag_reg <= irq_flag_next;
    end
  end

  // expiry action

  always_comb begin
    sys_reset_next = 1'b0;
    if (expire_w) begin
      unique case (mode_w)
        ewwrf_pkg::EWWRF_MODE_STOPPED: sys_reset_next = 1'b0;
        ewwrf_pkg::EWWRF_MODE_IRQ: sys_reset_next = 1'b0; // [RULE_03]
        ewwrf_pkg::EWWRF_MODE_RESET: sys_reset_next = 1'b1; // [RULE_04] [RULE_19]
        // a second expiry with the vector still unserved resets
        ewwrf_pkg::EWWRF_MODE_COMBINED: sys_reset_next = irq_flag_reg; // [RULE_05]
      endcase
    end
  end

  // request gated by both enables; wake does not need the global bit
  assign irq_out_next = irq_flag_reg & eff_irq_en_w & i_global_irq_enable; // [RULE_18]
  assign wake_next = irq_flag_reg & eff_irq_en_w; // [RULE_03]

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_guard_system_reset <= 1'b0;
      o_guard_irq <= 1'b0;
      o_guard_wake <= 1'b0;
      o_guard_running <= 1'b0;
    end else begin
      o_guard_system_reset <= sys_reset_next & ~o_guard_system_reset;
      o_guard_irq <= irq_out_next & ~chip_reset_w;
      o_guard_wake <= wake_next & ~chip_reset_w;
      o_guard_running <= running_w;
    end
  end

  // reset-cause flags

  logic [3:0] cause_keep_w;
  logic [3:0] cause_set_w;

  // writes can only clear; a one written leaves the flag alone
  assign cause_keep_w = wr_cause_w ? (cause_reg & i_wdata[3:0]) : cause_reg; // [RULE_11] [RULE_12] [RULE_13] [RULE_14]
  assign cause_set_w = {o_guard_system_reset, i_brownout_reset, i_pin_reset, 1'b0}; // [RULE_11] [RULE_12] [RULE_13]

  // power-on clears the three event flags and sets its own
  assign cause_next = cause_keep_w | cause_set_w; // [RULE_14]

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      cause_reg <= `EWWRF_CAUSE_POR_VALUE; // [RULE_11] [RULE_12] [RULE_13] [RULE_14]
    end else begin
      cause_reg <= cause_next;
    end
  end

  // read data, valid the cycle after the strobe

  logic [7:0] ctl_view_w;
  logic [7:0] cause_view_w;

  assign ctl_view_w = {irq_flag_reg, eff_irq_en_w, pre_reg[3], in_win_w,
                       eff_rst_en_w, pre_reg[2:0]}; // [RULE_16] [RULE_22] [RULE_06]
  assign cause_view_w = {4'h0, cause_reg}; // [RULE_15]

  assign rdata_next = !i_rd ? 8'h00 :
                      hit_ctl_w ? ctl_view_w :
                      hit_cause_w ? cause_view_w :
                      8'h00;

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= rdata_next;
    end
  end

endmodule : ewwrf_guard_timer

// ==== ewwrf_guard_timer_checker.sv ====
// port assertions of the guard timer
`timescale 1ns/10ps

module ewwrf_guard_timer_checker (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_guard_always_on_fuse,
  input wire logic i_global_irq_enable,
  input wire logic i_irq_vector_taken,
  input wire logic [7:0] o_rdata,
  input wire logic o_guard_irq,
  input wire logic o_guard_wake,
  input wire logic o_guard_system_reset,
  input wire logic o_guard_running
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_reset);

  rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data not zero outside a read");
  cause_high_a: assert property ($past(i_rd) && $past(i_addr) == 8'h55 |-> o_rdata[7:4] == 4'h0)
    else $error("unused cause bits not zero");
  fuse_read_a: assert property ($past(i_rd) && $past(i_addr) == 8'h60 && $past(i_guard_always_on_fuse)
    |-> o_rdata[3] && !o_rdata[6])
    else $error("fuse does not force the enables");
  fuse_run_a: assert property (!$past(i_reset) && $past(i_guard_always_on_fuse) |-> o_guard_running)
    else $error("fuse set but timer stopped");
  rst_pulse_a: assert property (o_guard_system_reset |=> !o_guard_system_reset)
    else $error("system reset longer than one cycle");
  rst_cause_a: assert property (o_guard_system_reset |-> $past(o_guard_running))
    else $error("system reset while timer stopped");
  irq_gate_a: assert property (o_guard_irq |-> o_guard_wake && $past(i_global_irq_enable))
    else $error("interrupt without both enables");
  irq_global_a: assert property (o_guard_wake && $past(i_global_irq_enable) |-> o_guard_irq)
    else $error("interrupt missing with both enables");
  vec_clear_a: assert property (i_irq_vector_taken |-> ##2 !o_guard_wake)
    else $error("vector did not clear the flag");
  win_open_a: assert property (i_wr && i_addr == 8'h60 && i_wdata[4] && i_wdata[3]
    ##2 i_rd && i_addr == 8'h60 |=> o_rdata[4])
    else $error("change window not open after opening write");

  cover property (o_guard_system_reset);
  cover property (o_guard_irq);
  cover property (i_irq_vector_taken ##2 !o_guard_wake);
endmodule : ewwrf_guard_timer_checker

bind ewwrf_guard_timer ewwrf_guard_timer_checker u_chk (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_guard_always_on_fuse(i_guard_always_on_fuse),
  .i_global_irq_enable(i_global_irq_enable), .i_irq_vector_taken(i_irq_vector_taken), .o_rdata(o_rdata),
  .o_guard_irq(o_guard_irq), .o_guard_wake(o_guard_wake), .o_guard_system_reset(o_guard_system_reset),
  .o_guard_running(o_guard_running));

// ==== ewwrf_cpu_model.sv ====
// cpu side model: register master, restart instruction, guard oscillator
`timescale 1ns/10ps

module ewwrf_cpu_model (
  input wire logic i_sys_clk,
  input wire logic [7:0] i_rdata,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata,
  output logic o_wr,
  output logic o_rd,
  output logic o_restart,
  output logic o_osc
);
  logic [1:0] osc_cnt = 2'h0;

  initial begin
    o_addr = 8'h00;
    o_wdata = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_restart = 1'b0;
    o_osc = 1'b0;
  end

  // free running, three cycles a half: well within what the synchroniser tolerates
  always @(posedge i_sys_clk) begin
    osc_cnt <= (osc_cnt == 2'h2) ? 2'h0 : osc_cnt + 2'h1;
    if (osc_cnt == 2'h2) o_osc <= ~o_osc;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    o_wr <= 1'b1;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_sys_clk);
    o_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_sys_clk);
    o_rd <= 1'b1;
    o_addr <= a;
    @(posedge i_sys_clk);
    o_rd <= 1'b0;
    #1;
    d = i_rdata;
  endtask : rd

  task automatic restart();
    @(posedge i_sys_clk);
    o_restart <= 1'b1;
    @(posedge i_sys_clk);
    o_restart <= 1'b0;
  endtask : restart

  // restart first so a shorter period cannot expire at once
  task automatic change(input logic [7:0] d);
    restart();
    wr(8'h60, 8'h18);
    wr(8'h60, d);
  endtask : change
endmodule : ewwrf_cpu_model

// ==== ewwrf_guard_timer_tb.sv ====
// self-checking bench of the guard timer
`timescale 1ns/10ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin fail_count++; \
  $display("mismatch at %0t: got %h, expected %h", $time, (a), (e)); end end

module ewwrf_guard_timer_tb;
  logic i_sys_clk = 1'b0;
  logic i_reset = 1'b1;
  logic fuse = 1'b0;
  logic gie = 1'b0;
  logic vec = 1'b0;
  logic pin = 1'b0;
  logic bo = 1'b0;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic wr, rd, rst_cmd, osc, irq, wake, sys_rst, running;
  int fail_count = 0;
  int num_checks = 0;
  int n;
  logic seen;

  always #50 i_sys_clk = ~i_sys_clk;

  ewwrf_cpu_model cpu (.i_sys_clk(i_sys_clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata), .o_wr(wr),
    .o_rd(rd), .o_restart(rst_cmd), .o_osc(osc));

  ewwrf_guard_timer DUT (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .i_guard_osc(osc), .i_guard_restart(rst_cmd), .i_guard_always_on_fuse(fuse),
    .i_global_irq_enable(gie), .i_irq_vector_taken(vec), .i_brownout_reset(bo), .i_pin_reset(pin),
    .o_rdata(rdata), .o_guard_irq(irq), .o_guard_wake(wake), .o_guard_system_reset(sys_rst),
    .o_guard_running(running));

  task automatic results();
    $display("checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    cpu.rd(a, d);
    `CHK(d, e)
  endtask : rd_chk

  // one-cycle pulse on vector, pin reset, brown-out
  task automatic pulse(input logic [2:0] m);
    @(posedge i_sys_clk);
    {vec, pin, bo} <= m;
    @(posedge i_sys_clk);
    {vec, pin, bo} <= 3'h0;
  endtask : pulse

  // bounded wait for interrupt or system reset; notes any reset seen meanwhile
  task automatic wait_for(input logic want_irq);
    n = 0;
    while (n < 13000 && ((want_irq ? irq : sys_rst) !== 1'b1)) begin
      @(posedge i_sys_clk);
      #1;
      n++;
      if (sys_rst === 1'b1) seen = 1'b1;
    end
    if (n >= 13000) begin
      fail_count++;
      results();
    end
  endtask : wait_for

  task automatic t_reset_vals();
    rd_chk(8'h55, 8'h01);
    rd_chk(8'h60, 8'h00);
    // ones written to the cause register neither clear flags nor show in the unused bits
    cpu.wr(8'h55, 8'hff);
    rd_chk(8'h55, 8'h01);
  endtask : t_reset_vals

  task automatic t_fuse();
    cpu.wr(8'h60, 8'h40);
    @(posedge i_sys_clk);
    fuse <= 1'b1;
    rd_chk(8'h60, 8'h08);
    @(posedge i_sys_clk);
    fuse <= 1'b0;
    cpu.wr(8'h60, 8'h00);
    rd_chk(8'h60, 8'h00);
  endtask : t_fuse

  task automatic t_cause();
    pulse(3'b001);
    pulse(3'b010);
    rd_chk(8'h55, 8'h07);
    cpu.wr(8'h55, 8'h06);
    rd_chk(8'h55, 8'h06);
    cpu.wr(8'h55, 8'h00);
    pulse(3'b010);
    rd_chk(8'h55, 8'h02);
    cpu.wr(8'h55, 8'h00);
    rd_chk(8'h55, 8'h00);
  endtask : t_cause

  task automatic t_window();
    cpu.change(8'h0d);
    rd_chk(8'h60, 8'h0d);
    cpu.wr(8'h60, 8'h00);
    rd_chk(8'h60, 8'h0d);
    cpu.wr(8'h60, 8'h18);
    rd_chk(8'h60, 8'h1d);
    repeat (5) @(posedge i_sys_clk);
    rd_chk(8'h60, 8'h0d);
    cpu.wr(8'h60, 8'h00);
    rd_chk(8'h60, 8'h0d);
    cpu.change(8'h00);
    rd_chk(8'h60, 8'h00);
    `CHK(running, 1'b0)
  endtask : t_window

  task automatic t_reset_mode();
    seen = 1'b0;
    cpu.change(8'h08);
    repeat (2) begin
      repeat (8000) begin
        @(posedge i_sys_clk);
        #1;
        if (sys_rst === 1'b1) seen = 1'b1;
      end
      cpu.restart();
    end
    `CHK(seen, 1'b0)
    wait_for(1'b0);
    `CHK(n >= 12280 && n <= 12300, 1'b1)
    rd_chk(8'h55, 8'h08);
    rd_chk(8'h60, 8'h08);
    `CHK(running, 1'b1)
    cpu.change(8'h00);
    rd_chk(8'h60, 8'h08);
    cpu.wr(8'h55, 8'h00);
    cpu.change(8'h00);
    rd_chk(8'h60, 8'h00);
  endtask : t_reset_mode

  task automatic t_irq();
    seen = 1'b0;
    @(posedge i_sys_clk);
    gie <= 1'b1;
    cpu.wr(8'h60, 8'h40);
    wait_for(1'b1);
    `CHK(seen, 1'b0)
    rd_chk(8'h60, 8'hc0);
    @(posedge i_sys_clk);
    gie <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    #1;
    `CHK({irq, wake}, 2'b01)
    cpu.wr(8'h60, 8'hc0);
    repeat (2) @(posedge i_sys_clk);
    #1;
    `CHK(wake, 1'b0)
    rd_chk(8'h60, 8'h40);
  endtask : t_irq

  task automatic t_combined();
    seen = 1'b0;
    @(posedge i_sys_clk);
    gie <= 1'b1;
    cpu.wr(8'h60, 8'h48);
    cpu.restart();
    wait_for(1'b1);
    `CHK(seen, 1'b0)
    rd_chk(8'h60, 8'hc8);
    pulse(3'b100);
    rd_chk(8'h60, 8'h08);
    wait_for(1'b0);
    `CHK(sys_rst, 1'b1)
    rd_chk(8'h55, 8'h08);
  endtask : t_combined

  initial begin
    repeat (4) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    t_reset_vals();
    t_fuse();
    t_cause();
    t_window();
    t_reset_mode();
    t_irq();
    t_combined();
    results();
  end
endmodule : ewwrf_guard_timer_tb
